// >>> core/pacc_map.svh
// Register offsets, field positions, reset values and counts of the pulse accumulator
`ifndef PACC_MAP_SVH
`define PACC_MAP_SVH

// Byte offsets from the timer module base
`define PACC_CTRL_OFS   12'h020
`define PACC_COUNT_OFS  12'h024
`define PACC_STAT_OFS   12'h028
`define PACC_MASK_OFS   12'h02C
`define PACC_TSYS_OFS   12'h030

// Control register fields
`define PACC_EN_BIT     6
`define PACC_MODE_BIT   5
`define PACC_EDGE_BIT   4
`define PACC_OVIE_BIT   1
`define PACC_INIE_BIT   0
`define PACC_CTRL_WMASK 8'h7F

// Timer system control fields
`define PACC_TEN_BIT    7
`define PACC_SWAI_BIT   6
`define PACC_TSYS_WMASK 8'hC0

// Status and mask bit positions
`define PACC_IN_FLAG    0
`define PACC_OV_FLAG    1

// Reset values
`define PACC_CTRL_RST   8'h00
`define PACC_TSYS_RST   8'h00
`define PACC_MASK_RST   2'h3
`define PACC_COUNT_RST  16'h0000

// Bus clock divider for gated time accumulation
`define PACC_PRESCALE   64
`define PACC_PRE_LAST   6'h3F

`endif

// >>> core/pacc_pkg.sv
// Types shared by the pulse accumulator control logic
package pacc_pkg;

	// Control register layout
	typedef struct packed {
		logic       rsvd;
		logic       accum_system_enable;
		logic       accum_mode_select;
		logic       edge_polarity_select;
		logic [1:0] clk_sel;
		logic       overflow_irq_enable;
		logic       input_irq_enable;
	} accum_control_reg_t;

	// Timer system control layout
	typedef struct packed {
		logic       main_timer_enable;
		logic       stop_in_wait;
		logic [5:0] rsvd;
	} tsys_ctrl_t;

	// Whole state of the block
	typedef struct packed {
		accum_control_reg_t ctrl;
		tsys_ctrl_t         tsys;
		logic [15:0]        count;
		logic [1:0]         stat;
		logic [1:0]         mask;
		logic               pin_s1;
		logic               pin_s2;
		logic               pin_d;
		logic [5:0]         pre;
		logic [31:0]        rdata;
	} pacc_state_t;

endpackage

// >>> core/pulse_accum.sv
// Pulse accumulator control with APB register slave
`timescale 1ns/100ps
`include "pacc_map.svh"

module pulse_accum
	import pacc_pkg::*;
(
	// Clock and reset
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_B_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// Channel 7 pin and processor state
	input  wire logic        CH7_PIN_I,
	input  wire logic        WAIT_MODE_I,
	// Results
	output logic [15:0]      COUNT_O,
	output logic [1:0]       CLK_SEL_O,
	output logic             IRQ_O
);

	////////////////////////////////////////////////////////////////////////////
	// State and decode signals

	pacc_state_t st_r;
	pacc_state_t st_nxt;
	logic        wr_en;
	logic        rd_setup;
	logic        hit;
	logic        halt;
	logic        tick;
	logic        rise;
	logic        fall;
	logic        cnt_edge;
	logic        gate_on;
	logic        inc;
	logic        in_evt;
	logic        ov_evt;
	logic [1:0]  w1c;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	// Access phase writes, setup phase loads read data
	assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I & hit;
	assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;

	// Address hit
	always_comb begin
		unique case (PADDR_I)
			`PACC_CTRL_OFS:  hit = 1'b1;
			`PACC_COUNT_OFS: hit = 1'b1;
			`PACC_STAT_OFS:  hit = 1'b1;
			`PACC_MASK_OFS:  hit = 1'b1;
			`PACC_TSYS_OFS:  hit = 1'b1;
			default:         hit = 1'b0;
		endcase
	end

	// Read data selection, reserved bits zero
	always_comb begin
		unique case (PADDR_I)
			`PACC_CTRL_OFS:  rd_mux = {24'h000000, 1'b0, st_r.ctrl[6:0]};
			`PACC_COUNT_OFS: rd_mux = {16'h0000, st_r.count};
			`PACC_STAT_OFS:  rd_mux = {30'h00000000, st_r.stat};
			`PACC_MASK_OFS:  rd_mux = {30'h00000000, st_r.mask};
			`PACC_TSYS_OFS:  rd_mux = {24'h000000, st_r.tsys[7:6], 6'h00};
			default:         rd_mux = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin edges and time base

	// Edges from the second synchroniser stage only
	assign rise = st_r.pin_s2 & ~st_r.pin_d;
	assign fall = ~st_r.pin_s2 & st_r.pin_d;

	// Wait mode halt when stop-in-wait set
	assign halt = st_r.tsys.stop_in_wait & WAIT_MODE_I;

	// Divide-by-64 tick, absent with the main timer off
	assign tick = st_r.tsys.main_timer_enable & ~halt
		& (st_r.pre == `PACC_PRE_LAST);

	// Selected counting edge for event mode
	assign cnt_edge = st_r.ctrl.edge_polarity_select ? rise : fall;

	// Gate level for time accumulation
	assign gate_on = st_r.ctrl.edge_polarity_select
		? ~st_r.pin_s2 : st_r.pin_s2;

	////////////////////////////////////////////////////////////////////////////
	// Counting events

	// Increment request by mode, only while enabled
	always_comb begin
		inc    = 1'b0;
		in_evt = 1'b0;
		if (st_r.ctrl.accum_system_enable & ~halt) begin
			if (!st_r.ctrl.accum_mode_select) begin
				inc    = cnt_edge;
				in_evt = cnt_edge;
			end else begin
				inc    = tick & gate_on;
				// Trailing edge ends the gate
				in_evt = st_r.ctrl.edge_polarity_select ? rise : fall;
			end
		end
	end

	// Rollover from all ones
	assign ov_evt = inc & (st_r.count == 16'hFFFF);

	// Write-one-to-clear strobes for status
	assign w1c = (wr_en && PADDR_I == `PACC_STAT_OFS) ? PWDATA_I[1:0] : 2'h0;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_nxt = st_r;
		// Two-stage synchroniser and edge history
		st_nxt.pin_s1 = CH7_PIN_I;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.pin_d  = st_r.pin_s2;
		// Prescaler runs with the main timer
		if (st_r.tsys.main_timer_enable & ~halt) begin
			st_nxt.pre = st_r.pre + 6'h01;
		end else begin
			st_nxt.pre = 6'h00;
		end
		// Counter, software write wins
		if (inc) begin
			st_nxt.count = st_r.count + 16'h0001;
		end
		if (wr_en && PADDR_I == `PACC_COUNT_OFS) begin
			st_nxt.count = PWDATA_I[15:0];
		end
		// Sticky flags, set beats clear
		st_nxt.stat = st_r.stat & ~w1c;
		if (in_evt) begin
			st_nxt.stat[`PACC_IN_FLAG] = 1'b1;
		end
		if (ov_evt) begin
			st_nxt.stat[`PACC_OV_FLAG] = 1'b1;
		end
		// Register writes
		if (wr_en && PADDR_I == `PACC_CTRL_OFS) begin
			st_nxt.ctrl = PWDATA_I[7:0] & `PACC_CTRL_WMASK;
		end
		if (wr_en && PADDR_I == `PACC_MASK_OFS) begin
			st_nxt.mask = PWDATA_I[1:0];
		end
		if (wr_en && PADDR_I == `PACC_TSYS_OFS) begin
			st_nxt.tsys = PWDATA_I[7:0] & `PACC_TSYS_WMASK;
		end
		// Read data held through the access phase
		if (rd_setup) begin
			st_nxt.rdata = rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			st_r.ctrl   <= `PACC_CTRL_RST;
			st_r.tsys   <= `PACC_TSYS_RST;
			st_r.count  <= `PACC_COUNT_RST;
			st_r.stat   <= 2'h0;
			st_r.mask   <= `PACC_MASK_RST;
			st_r.pin_s1 <= 1'b0;
			st_r.pin_s2 <= 1'b0;
			st_r.pin_d  <= 1'b0;
			st_r.pre    <= 6'h00;
			st_r.rdata  <= 32'h00000000;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Zero wait states; unmapped access errors
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
	assign PRDATA_O  = st_r.rdata;
	assign COUNT_O   = st_r.count;
	assign CLK_SEL_O = st_r.ctrl.clk_sel;

	// Level interrupt from enabled, unmasked flags
	assign IRQ_O = |(st_r.stat & st_r.mask
		& {st_r.ctrl.overflow_irq_enable, st_r.ctrl.input_irq_enable});

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);

	// Software write to the counter
	logic cnt_wr;
	assign cnt_wr = wr_en && PADDR_I == `PACC_COUNT_OFS;

	// Counter frozen while disabled
	off_hold_a: assert property (
		!st_r.ctrl.accum_system_enable && !cnt_wr |=> $stable(st_r.count))
		else $error("count moved while disabled");

	// Event counting with main timer off
	sequence ev_edge_s;
		st_r.ctrl.accum_system_enable && !st_r.ctrl.accum_mode_select
			&& !halt && cnt_edge && !cnt_wr;
	endsequence
	timer_indep_a: assert property (
		ev_edge_s and !st_r.tsys.main_timer_enable
			|=> st_r.count == $past(st_r.count) + 16'h0001)
		else $error("no count with timer off");

	// Falling edge counts when edge bit clear
	fall_cnt_a: assert property (
		ev_edge_s and !st_r.ctrl.edge_polarity_select
			|-> fall ##1 st_r.count == $past(st_r.count) + 16'h0001)
		else $error("falling edge not counted");

	// Mode bit selects gated counting on ticks only
	sequence gated_s;
		st_r.ctrl.accum_system_enable && st_r.ctrl.accum_mode_select
			&& !halt && !cnt_wr;
	endsequence
	gate_notick_a: assert property (
		gated_s and !tick |=> $stable(st_r.count))
		else $error("gated count without tick");

	// Gate high counts in edge-zero mode
	gate_hi_a: assert property (
		gated_s and tick && !st_r.ctrl.edge_polarity_select && st_r.pin_s2
			|=> st_r.count == $past(st_r.count) + 16'h0001)
		else $error("high gate not counted");

	// Gate low counts in edge-one mode
	gate_lo_a: assert property (
		gated_s and tick && st_r.ctrl.edge_polarity_select && !st_r.pin_s2
			|=> st_r.count == $past(st_r.count) + 16'h0001)
		else $error("low gate not counted");

	// Trailing falling edge sets input flag
	trail_flag_a: assert property (
		gated_s and !st_r.ctrl.edge_polarity_select && fall
			|=> st_r.stat[`PACC_IN_FLAG])
		else $error("trailing edge flag missing");

	// Overflow interrupt follows flag and enable
	ovf_irq_a: assert property (
		st_r.stat[`PACC_OV_FLAG] && st_r.mask[`PACC_OV_FLAG]
			&& st_r.ctrl.overflow_irq_enable |-> IRQ_O)
		else $error("overflow irq missing");

	// Input enable clear blocks input interrupt
	in_irq_off_a: assert property (
		!st_r.ctrl.input_irq_enable && !st_r.stat[`PACC_OV_FLAG] |-> !IRQ_O)
		else $error("input irq not inhibited");

	// Control write lands next cycle
	ctrl_wr_a: assert property (
		wr_en && PADDR_I == `PACC_CTRL_OFS
			|=> st_r.ctrl[6:0] == $past(PWDATA_I[6:0]))
		else $error("control write lost");

	// No tick with main timer off
	no_tick_a: assert property (
		!st_r.tsys.main_timer_enable |-> !tick)
		else $error("tick with timer off");

	// No second tick eight cycles after a tick
	tick_gap_a: assert property (
		tick ##1 (st_r.tsys.main_timer_enable && !halt) [*8] |-> !tick)
		else $error("tick too soon");

	// Wait mode with stop-in-wait set halts counting
	wait_halt_a: assert property (
		halt && !cnt_wr |=> $stable(st_r.count))
		else $error("count moved in wait");

	// Rollover sets overflow flag and wraps
	ovf_set_a: assert property (
		ov_evt && !cnt_wr |=> st_r.stat[`PACC_OV_FLAG] && st_r.count == 16'h0000)
		else $error("rollover not flagged");

	// Overflow flag stays until cleared
	ovf_sticky_a: assert property (
		st_r.stat[`PACC_OV_FLAG] && w1c[`PACC_OV_FLAG] == 1'b0
			|=> st_r.stat[`PACC_OV_FLAG])
		else $error("overflow flag dropped");

	// Clock select reflected on output
	clk_sel_a: assert property (
		wr_en && PADDR_I == `PACC_CTRL_OFS |=> CLK_SEL_O == $past(PWDATA_I[3:2]))
		else $error("clock select lost");

	// Read data matches register after setup
	ctrl_read_a: assert property (
		rd_setup && PADDR_I == `PACC_CTRL_OFS
			|=> PRDATA_O == {25'h0000000, $past(st_r.ctrl[6:0])})
		else $error("control readback wrong");

	// Rising edge counts when edge bit set
	rise_cnt_a: assert property (
		ev_edge_s and st_r.ctrl.edge_polarity_select
			|-> rise ##1 st_r.count == $past(st_r.count) + 16'h0001)
		else $error("rising edge not counted");

	// Input interrupt follows flag and enable
	in_irq_a: assert property (
		st_r.stat[`PACC_IN_FLAG] && st_r.mask[`PACC_IN_FLAG]
			&& st_r.ctrl.input_irq_enable |-> IRQ_O)
		else $error("input irq missing");

	// Trailing rising edge sets input flag
	trail_rise_a: assert property (
		gated_s and st_r.ctrl.edge_polarity_select && rise
			|=> st_r.stat[`PACC_IN_FLAG])
		else $error("trailing rise flag missing");

endmodule

// >>> sim/pin_drive.sv
// Far-side pulse and gate source on the channel 7 pin
`timescale 1ns/100ps

module pin_drive (
	// Clock
	input  wire logic clk_i,
	// Pin level
	output logic      pin_o
);
	// Idle low at time zero
	initial pin_o = 1'b0;

	// One pulse on the shared channel 7 pin, high then low
	task automatic pulse(input int hi, input int lo);
		@(posedge clk_i) pin_o <= 1'b1;
		repeat (hi) @(posedge clk_i);
		pin_o <= 1'b0;
		repeat (lo) @(posedge clk_i);
	endtask

	// Static gate level
	task automatic level(input logic v);
		@(posedge clk_i) pin_o <= v;
	endtask
endmodule

// >>> sim/pulse_accum_tb.sv
// Self-checking bench for the pulse accumulator
`timescale 1ns/100ps

module pulse_accum_tb;
	import pacc_pkg::*;

	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        wait_mode = 1'b0;
	logic [15:0] count;
	logic [1:0]  clk_sel;
	logic        irq;
	logic [31:0] q;
	logic        err;
	int          n_fail = 0;
	int          checked = 0;
	int          cyc = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock, design and far side
	always #4 clk = ~clk;

	pulse_accum uut (
		.SYS_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .CH7_PIN_I(pin),
		.WAIT_MODE_I(wait_mode), .COUNT_O(count), .CLK_SEL_O(clk_sel), .IRQ_O(irq)
	);

	pin_drive src (.clk_i(clk), .pin_o(pin));

	////////////////////////////////////////////////////////////////////////////////
	// Checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB master: setup, access until pready, then release
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// Count lies within one prescaler tick of four
	task automatic rd_range;
		apb(1'b0, 12'h024, 32'h0);
		chk({31'h0, q >= 32'h3 && q <= 32'h5}, 32'h1);
	endtask

	task automatic pulses(input int n);
		repeat (n) src.pulse(4, 6);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values and access
		rd(12'h020, 32'h0);
		rd(12'h024, 32'h0);
		rd(12'h02C, 32'h3);
		wr(12'h020, 32'hFF);
		rd(12'h020, 32'h7F);
		chk({31'h0, err}, 32'h0);
		chk({31'h0, pready}, 32'h1);
		chk({30'h0, clk_sel}, 32'h3);
		apb(1'b0, 12'h040, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(q, 32'h0);
		// Disabled: mode and edge set, nothing counted
		wr(12'h020, 32'h30);
		wr(12'h024, 32'h0);
		pulses(2);
		rd(12'h024, 32'h0);
		// Event counting on each edge, main timer off
		for (int e = 0; e < 2; e++) begin
			wr(12'h020, 32'h40 | (e << 4));
			wr(12'h024, 32'h0);
			wr(12'h028, 32'h3);
			pulses(3);
			rd(12'h024, 32'h3);
			rd(12'h028, 32'h1);
			chk({16'h0, count}, 32'h3);
		end
		// Input interrupt, mask and clear
		wr(12'h020, 32'h41);
		@(negedge clk) chk({31'h0, irq}, 32'h1);
		wr(12'h02C, 32'h2);
		@(negedge clk) chk({31'h0, irq}, 32'h0);
		wr(12'h02C, 32'h3);
		wr(12'h028, 32'h1);
		@(negedge clk) chk({31'h0, irq}, 32'h0);
		// Rollover and overflow interrupt
		wr(12'h020, 32'h42);
		wr(12'h024, 32'hFFFF);
		pulses(1);
		rd(12'h024, 32'h0);
		rd(12'h028, 32'h3);
		@(negedge clk) chk({31'h0, irq}, 32'h1);
		wr(12'h020, 32'h40);
		@(negedge clk) chk({31'h0, irq}, 32'h0);
		// Stop in wait
		wr(12'h030, 32'hC0);
		wait_mode <= 1'b1;
		wr(12'h024, 32'h0);
		pulses(2);
		rd(12'h024, 32'h0);
		wait_mode <= 1'b0;
		pulses(2);
		rd(12'h024, 32'h2);
		// Gated, edge zero: no time base while main timer off
		wr(12'h030, 32'h0);
		wr(12'h020, 32'h60);
		wr(12'h024, 32'h0);
		src.pulse(200, 6);
		rd(12'h024, 32'h0);
		wr(12'h030, 32'h80);
		wr(12'h024, 32'h0);
		wr(12'h028, 32'h3);
		src.pulse(256, 6);
		rd_range();
		rd(12'h028, 32'h1);
		// Gated, edge one: counts while low, flag on rising
		src.level(1'b1);
		wr(12'h020, 32'h70);
		wr(12'h024, 32'h0);
		wr(12'h028, 32'h3);
		src.level(1'b0);
		repeat (256) @(posedge clk);
		src.level(1'b1);
		repeat (6) @(posedge clk);
		rd_range();
		rd(12'h028, 32'h1);
		// Mid-run reset returns every register to its reset value
		rd(12'h030, 32'h80);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd(12'h020, 32'h0);
		rd(12'h024, 32'h0);
		rd(12'h028, 32'h0);
		rd(12'h02C, 32'h3);
		rd(12'h030, 32'h0);
		chk({31'h0, irq}, 32'h0);
		chk({30'h0, clk_sel}, 32'h0);
		stop_test();
	end
endmodule
